/* File: design/ifp_pkg.sv */
// constants shared by the interrupt flag and priority bank
package ifp_pkg;

    // ************************************************************
    // register bus geometry
    // ************************************************************
    localparam int          ADDR_W     = 3;
    localparam int          DATA_W     = 16;
    localparam int          FLAG_WORDS = 5;

    // ************************************************************
    // register indexes on the plain port
    // ************************************************************
    localparam logic [2:0]  IDX_FLAGS_1       = 3'h0;
    localparam logic [2:0]  IDX_FLAGS_2       = 3'h1;
    localparam logic [2:0]  IDX_FLAGS_3       = 3'h2;
    localparam logic [2:0]  IDX_FLAGS_4       = 3'h3;
    localparam logic [2:0]  IDX_FLAGS_5       = 3'h4;
    localparam logic [2:0]  IDX_T3G_PRIORITY  = 3'h5;

    // ************************************************************
    // field positions, flag word 1
    // ************************************************************
    localparam int          POS_UART2_TX_FLAG       = 15;
    localparam int          POS_UART2_RX_FLAG       = 14;
    localparam int          POS_EXT_IRQ2_FLAG       = 13;
    localparam int          POS_TIMER4_FLAG         = 11;
    localparam int          POS_CAPCMP3_FLAG        = 9;
    localparam int          POS_EXT_IRQ1_FLAG       = 4;
    localparam int          POS_INPUT_CHANGE_FLAG   = 3;
    localparam int          POS_COMPARATOR_FLAG     = 2;
    localparam int          POS_SERIAL1_COLL_FLAG   = 1;
    localparam int          POS_SERIAL1_EVENT_FLAG  = 0;

    // ************************************************************
    // field positions, flag words 2 to 5 and priority
    // ************************************************************
    localparam int          POS_TIMER3_GATE_FLAG    = 5;
    localparam int          POS_SERIAL2_COLL_FLAG   = 2;
    localparam int          POS_SERIAL2_EVENT_FLAG  = 1;
    localparam int          POS_VOLTAGE_DETECT_FLAG = 8;
    localparam int          POS_UART2_ERROR_FLAG    = 2;
    localparam int          POS_UART1_ERROR_FLAG    = 1;
    localparam int          POS_LOW_POWER_WAKE_FLAG = 0;
    localparam int          POS_T3G_PRIO_LSB        = 4;
    localparam int          POS_T3G_PRIO_MSB        = 6;

    // ************************************************************
    // implemented-bit masks, full and reduced family members
    // ************************************************************
    localparam logic [15:0] MASK_FLAGS_1_FULL  = 16'hEA1F;
    localparam logic [15:0] MASK_FLAGS_1_RED   = 16'h201F;
    localparam logic [15:0] MASK_FLAGS_2       = 16'h0020;
    localparam logic [15:0] MASK_FLAGS_3_FULL  = 16'h0006;
    localparam logic [15:0] MASK_FLAGS_3_RED   = 16'h0000;
    localparam logic [15:0] MASK_FLAGS_4_FULL  = 16'h0106;
    localparam logic [15:0] MASK_FLAGS_4_RED   = 16'h0102;
    localparam logic [15:0] MASK_FLAGS_5       = 16'h0001;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] RST_FLAGS          = 16'h0000;
    localparam logic [2:0]  RST_T3G_PRIO       = 3'h4;
    localparam logic [2:0]  PRIO_DISABLED      = 3'h0;
    localparam logic [15:0] RDATA_IDLE         = 16'h0000;

endpackage : ifp_pkg

/* File: design/ifp_flag_word.sv */
// one 16-bit interrupt flag word with per-bit implemented mask
`timescale 1ns/10ps

module ifp_flag_word #(
    parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    // software write port
    input  wire logic        wr_in,
    input  wire logic [15:0] wdata_in,
    // peripheral event pulses
    input  wire logic [15:0] evt_in,
    // stored flags
    output logic      [15:0] flags_out
);

    logic [15:0] flag_next;

    // ************************************************************
    // next value per bit, constant zero where no flag is built
    // ************************************************************
    genvar b;
    generate
        for (b = 0; b < 16; b = b + 1) begin : g_bit
            if (IMPL_MASK[b]) begin : g_impl
                // the event is or-ed last so it beats a clearing write
                assign flag_next[b] = evt_in[b] | (wr_in ? wdata_in[b] : flags_out[b]);
            end else begin : g_unimpl
                assign flag_next[b] = 1'b0;
            end
        end
    endgenerate

    // one register for the whole word keeps one driver; bits stuck at zero synthesise away
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flags_out <= ifp_pkg::RST_FLAGS;
        end else begin
            flags_out <= flag_next;
        end
    end

endmodule : ifp_flag_word

/* File: design/ifp_flag_bank.sv */
// interrupt flag and timer3 gate priority bank
//
// Summary of operation
// - flag reads 1 after request, clears at reset
// - unimplemented flag and priority bits read zero
// - word1 high bits: uart2, irq2, timer4, capcmp3
// - word1 low bits: irq1, change, comparator, serial1
// - word2 holds only timer3 gate flag bit5
// - word3 holds serial2 collision bit2, event bit1
// - word4: voltage detect 8, uart errors 2,1
// - word5 holds only low power wake bit0
// - priority field bits 6-4, resets to 100
// - priority 000 blocks timer3 gate request
// - reduced members drop optional peripheral flag bits
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps

module ifp_flag_bank #(
    parameter bit FULL_MEMBER = 1'b1
) (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rstn_in,
    // register port
    input  wire logic [2:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    // peripheral event pulses, one vector per flag word
    input  wire logic [15:0] evt1_in,
    input  wire logic [15:0] evt2_in,
    input  wire logic [15:0] evt3_in,
    input  wire logic [15:0] evt4_in,
    input  wire logic [15:0] evt5_in,
    // flag state towards the core
    output logic      [15:0] flags1_out,
    output logic      [15:0] flags2_out,
    output logic      [15:0] flags3_out,
    output logic      [15:0] flags4_out,
    output logic      [15:0] flags5_out,
    // timer3 gate request and its priority
    output logic      [2:0]  t3g_prio_out,
    output logic             t3g_req_out
);

    // ************************************************************
    // implemented masks for this family member
    // ************************************************************
    localparam logic [15:0] MASK1 = FULL_MEMBER ? ifp_pkg::MASK_FLAGS_1_FULL
                                                : ifp_pkg::MASK_FLAGS_1_RED;
    localparam logic [15:0] MASK2 = ifp_pkg::MASK_FLAGS_2;
    localparam logic [15:0] MASK3 = FULL_MEMBER ? ifp_pkg::MASK_FLAGS_3_FULL
                                                : ifp_pkg::MASK_FLAGS_3_RED;
    localparam logic [15:0] MASK4 = FULL_MEMBER ? ifp_pkg::MASK_FLAGS_4_FULL
                                                : ifp_pkg::MASK_FLAGS_4_RED;
    localparam logic [15:0] MASK5 = ifp_pkg::MASK_FLAGS_5;

    // ************************************************************
    // address decode
    // ************************************************************
    logic        wr_flags1;
    logic        wr_flags2;
    logic        wr_flags3;
    logic        wr_flags4;
    logic        wr_flags5;
    logic        wr_prio;

    // each write strobe reaches at most one register; indexes 6 and 7 reach none
    assign wr_flags1 = wr_in && (addr_in == ifp_pkg::IDX_FLAGS_1);
    assign wr_flags2 = wr_in && (addr_in == ifp_pkg::IDX_FLAGS_2);
    assign wr_flags3 = wr_in && (addr_in == ifp_pkg::IDX_FLAGS_3);
    assign wr_flags4 = wr_in && (addr_in == ifp_pkg::IDX_FLAGS_4);
    assign wr_flags5 = wr_in && (addr_in == ifp_pkg::IDX_FLAGS_5);
    assign wr_prio   = wr_in && (addr_in == ifp_pkg::IDX_T3G_PRIORITY);

    // ************************************************************
    // flag words
    // ************************************************************
    ifp_flag_word #(.IMPL_MASK(MASK1)) u_flags1 (
        .mclk_in   (mclk_in),
        .rstn_in   (rstn_in),
        .wr_in     (wr_flags1),
        .wdata_in  (wdata_in),
        .evt_in    (evt1_in),
        .flags_out (flags1_out)
    );

    ifp_flag_word #(.IMPL_MASK(MASK2)) u_flags2 (
        .mclk_in   (mclk_in),
        .rstn_in   (rstn_in),
        .wr_in     (wr_flags2),
        .wdata_in  (wdata_in),
        .evt_in    (evt2_in),
        .flags_out (flags2_out)
    );

    ifp_flag_word #(.IMPL_MASK(MASK3)) u_flags3 (
        .mclk_in   (mclk_in),
        .rstn_in   (rstn_in),
        .wr_in     (wr_flags3),
        .wdata_in  (wdata_in),
        .evt_in    (evt3_in),
        .flags_out (flags3_out)
    );

    ifp_flag_word #(.IMPL_MASK(MASK4)) u_flags4 (
        .mclk_in   (mclk_in),
        .rstn_in   (rstn_in),
        .wr_in     (wr_flags4),
        .wdata_in  (wdata_in),
        .evt_in    (evt4_in),
        .flags_out (flags4_out)
    );

    ifp_flag_word #(.IMPL_MASK(MASK5)) u_flags5 (
        .mclk_in   (mclk_in),
        .rstn_in   (rstn_in),
        .wr_in     (wr_flags5),
        .wdata_in  (wdata_in),
        .evt_in    (evt5_in),
        .flags_out (flags5_out)
    );

    // ************************************************************
    // timer3 gate priority and request
    // ************************************************************
    logic [2:0]  prio_next;
    logic        t3g_flag;
    logic        req_next;

    assign prio_next = wr_prio ? wdata_in[ifp_pkg::POS_T3G_PRIO_MSB:ifp_pkg::POS_T3G_PRIO_LSB]
                               : t3g_prio_out;
    assign t3g_flag  = flags2_out[ifp_pkg::POS_TIMER3_GATE_FLAG];
    // a zero priority masks the source entirely, whatever the flag says
    assign req_next  = t3g_flag && (t3g_prio_out != ifp_pkg::PRIO_DISABLED);

    // priority register resets to the mid level
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            t3g_prio_out <= ifp_pkg::RST_T3G_PRIO;
        end else begin
            t3g_prio_out <= prio_next;
        end
    end

    // request is registered so the core sees a clean level
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            t3g_req_out <= 1'b0;
        end else begin
            t3g_req_out <= req_next;
        end
    end

    // ************************************************************
    // read data path
    // ************************************************************
    logic [15:0] prio_word;
    logic [15:0] rd_sel;
    logic [15:0] rdata_next;

    // priority field placed in bits 6-4, other positions zero
    assign prio_word = {9'h000, t3g_prio_out, 4'h0};

    // unmapped indexes answer zero
    assign rd_sel = (addr_in == ifp_pkg::IDX_FLAGS_1)      ? flags1_out :
                    (addr_in == ifp_pkg::IDX_FLAGS_2)      ? flags2_out :
                    (addr_in == ifp_pkg::IDX_FLAGS_3)      ? flags3_out :
                    (addr_in == ifp_pkg::IDX_FLAGS_4)      ? flags4_out :
                    (addr_in == ifp_pkg::IDX_FLAGS_5)      ? flags5_out :
                    (addr_in == ifp_pkg::IDX_T3G_PRIORITY) ? prio_word  :
                                                             ifp_pkg::RDATA_IDLE;
    // data stand only in the cycle after the strobe, zero otherwise
    assign rdata_next = rd_in ? rd_sel : ifp_pkg::RDATA_IDLE;

    // read data register
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= ifp_pkg::RDATA_IDLE;
        end else begin
            rdata_out <= rdata_next;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************

    // unimplemented flag positions never show a one
    property p_unimpl_zero;
        @(posedge mclk_in) disable iff (!rstn_in)
        ((flags1_out & ~MASK1) == 16'h0000) && ((flags2_out & ~MASK2) == 16'h0000) &&
        ((flags3_out & ~MASK3) == 16'h0000) && ((flags4_out & ~MASK4) == 16'h0000) &&
        ((flags5_out & ~MASK5) == 16'h0000);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented flag bit reads one");

    // an event on an implemented word1 bit is seen next cycle
    property p_word1_event;
        @(posedge mclk_in) disable iff (!rstn_in)
        ((evt1_in & MASK1) != 16'h0000) |=> ((flags1_out & $past(evt1_in) & MASK1) == ($past(evt1_in) & MASK1));
    endproperty
    a_word1_event: assert property (p_word1_event)
        else $error("word1 event not captured");

    // timer3 gate event sets bit 5 of word2
    property p_t3g_event;
        @(posedge mclk_in) disable iff (!rstn_in)
        evt2_in[ifp_pkg::POS_TIMER3_GATE_FLAG] |=> flags2_out[ifp_pkg::POS_TIMER3_GATE_FLAG];
    endproperty
    a_t3g_event: assert property (p_t3g_event)
        else $error("timer3 gate flag not set by event");

    // low power wake event sets bit 0 of word5
    property p_wake_event;
        @(posedge mclk_in) disable iff (!rstn_in)
        evt5_in[ifp_pkg::POS_LOW_POWER_WAKE_FLAG] |=> flags5_out[ifp_pkg::POS_LOW_POWER_WAKE_FLAG];
    endproperty
    a_wake_event: assert property (p_wake_event)
        else $error("wake flag not set by event");

    // voltage detect event sets bit 8 of word4 and it holds without a write
    property p_hlv_hold;
        @(posedge mclk_in) disable iff (!rstn_in)
        evt4_in[ifp_pkg::POS_VOLTAGE_DETECT_FLAG] ##1 (!wr_flags4)[*2]
        |-> flags4_out[ifp_pkg::POS_VOLTAGE_DETECT_FLAG];
    endproperty
    a_hlv_hold: assert property (p_hlv_hold)
        else $error("voltage detect flag lost without a write");

    // a write with no event stores the written value
    property p_write_store;
        @(posedge mclk_in) disable iff (!rstn_in)
        (wr_flags3 && (evt3_in == 16'h0000)) |=> (flags3_out == ($past(wdata_in) & MASK3));
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("word3 write not stored");

    // event beats a clearing write in the same cycle
    property p_event_wins;
        @(posedge mclk_in) disable iff (!rstn_in)
        (wr_flags1 && !wdata_in[ifp_pkg::POS_EXT_IRQ2_FLAG] && evt1_in[ifp_pkg::POS_EXT_IRQ2_FLAG])
        |=> flags1_out[ifp_pkg::POS_EXT_IRQ2_FLAG];
    endproperty
    a_event_wins: assert property (p_event_wins)
        else $error("clearing write beat a peripheral event");

    // without write or event the word stays unchanged
    property p_flags_stable;
        @(posedge mclk_in) disable iff (!rstn_in)
        (!wr_flags4 && (evt4_in == 16'h0000)) |=> $stable(flags4_out);
    endproperty
    a_flags_stable: assert property (p_flags_stable)
        else $error("word4 changed with no cause");

    // priority write lands in one cycle
    property p_prio_write;
        @(posedge mclk_in) disable iff (!rstn_in)
        wr_prio |=> (t3g_prio_out == $past(wdata_in[ifp_pkg::POS_T3G_PRIO_MSB:ifp_pkg::POS_T3G_PRIO_LSB]));
    endproperty
    a_prio_write: assert property (p_prio_write)
        else $error("priority field not written");

    // zero priority keeps the request low
    property p_prio_disable;
        @(posedge mclk_in) disable iff (!rstn_in)
        (t3g_prio_out == 3'h0) |=> !t3g_req_out;
    endproperty
    a_prio_disable: assert property (p_prio_disable)
        else $error("request raised with priority zero");

    // pending flag with live priority raises the request next cycle
    property p_req_raise;
        @(posedge mclk_in) disable iff (!rstn_in)
        (t3g_flag && (t3g_prio_out != 3'h0)) |=> t3g_req_out;
    endproperty
    a_req_raise: assert property (p_req_raise)
        else $error("request missing for enabled pending flag");

    // priority read shows the field in bits 6-4 only
    property p_prio_read;
        @(posedge mclk_in) disable iff (!rstn_in)
        (rd_in && (addr_in == ifp_pkg::IDX_T3G_PRIORITY))
        |=> (rdata_out == {9'h000, $past(t3g_prio_out), 4'h0});
    endproperty
    a_prio_read: assert property (p_prio_read)
        else $error("priority read data wrong");

    // read data are zero outside the cycle after a read strobe
    property p_rdata_idle;
        @(posedge mclk_in) disable iff (!rstn_in)
        !rd_in |=> (rdata_out == 16'h0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without a read");

    // a word1 read returns the flags as they stood at the strobe
    property p_flags1_read;
        @(posedge mclk_in) disable iff (!rstn_in)
        (rd_in && (addr_in == ifp_pkg::IDX_FLAGS_1)) |=> (rdata_out == $past(flags1_out));
    endproperty
    a_flags1_read: assert property (p_flags1_read)
        else $error("word1 read data wrong");

    // the two unmapped indexes answer zero
    property p_unmapped_read;
        @(posedge mclk_in) disable iff (!rstn_in)
        (rd_in && (addr_in > ifp_pkg::IDX_T3G_PRIORITY)) |=> (rdata_out == 16'h0000);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped index read not zero");

    // priority only moves on its own write
    property p_prio_hold;
        @(posedge mclk_in) disable iff (!rstn_in)
        !wr_prio |=> $stable(t3g_prio_out);
    endproperty
    a_prio_hold: assert property (p_prio_hold)
        else $error("priority changed without a write");

    // no pending flag, no request
    property p_req_drop;
        @(posedge mclk_in) disable iff (!rstn_in)
        !t3g_flag |=> !t3g_req_out;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("request raised with no pending flag");

    // a word5 write with no event stores the written value
    property p_word5_store;
        @(posedge mclk_in) disable iff (!rstn_in)
        (wr_flags5 && (evt5_in == 16'h0000)) |=> (flags5_out == ($past(wdata_in) & MASK5));
    endproperty
    a_word5_store: assert property (p_word5_store)
        else $error("word5 write not stored");

    // a clearing write with no event drops the timer3 gate flag
    property p_t3g_clear;
        @(posedge mclk_in) disable iff (!rstn_in)
        (wr_flags2 && !wdata_in[ifp_pkg::POS_TIMER3_GATE_FLAG] && !evt2_in[ifp_pkg::POS_TIMER3_GATE_FLAG])
        |=> !flags2_out[ifp_pkg::POS_TIMER3_GATE_FLAG];
    endproperty
    a_t3g_clear: assert property (p_t3g_clear)
        else $error("timer3 gate flag not cleared");

    // an event on an implemented word3 bit is seen next cycle
    property p_word3_event;
        @(posedge mclk_in) disable iff (!rstn_in)
        ((evt3_in & MASK3) != 16'h0000) |=> ((flags3_out & $past(evt3_in) & MASK3) == ($past(evt3_in) & MASK3));
    endproperty
    a_word3_event: assert property (p_word3_event)
        else $error("word3 event not captured");

endmodule : ifp_flag_bank

/* File: testbench/ifp_event_src.sv */
// peripheral event source model driving the flag bank event inputs
`timescale 1ns/10ps

module ifp_event_src (
    // clock
    input  wire logic        mclk_in,
    // event pulses towards the flag bank
    output logic      [15:0] evt1_out,
    output logic      [15:0] evt2_out,
    output logic      [15:0] evt3_out,
    output logic      [15:0] evt4_out,
    output logic      [15:0] evt5_out
);
    logic [15:0] evt_reg [5];

    // sources keep their lines low between pulses so no stale event leaks in
    initial begin
        for (int i = 0; i < 5; i++) begin
            evt_reg[i] = 16'h0000;
        end
    end

    // one vector per flag word
    assign evt1_out = evt_reg[0];
    assign evt2_out = evt_reg[1];
    assign evt3_out = evt_reg[2];
    assign evt4_out = evt_reg[3];
    assign evt5_out = evt_reg[4];

    // one-cycle event pulse, launched just after a rising edge
    task automatic pulse(input logic [2:0] word, input logic [15:0] bits);
        @(posedge mclk_in);
        evt_reg[word] <= bits;
        @(posedge mclk_in);
        evt_reg[word] <= 16'h0000;
    endtask : pulse
endmodule : ifp_event_src

/* File: testbench/ifp_flag_bank_test.sv */
// self-checking testbench for the interrupt flag and priority bank
`timescale 1ns/10ps

module ifp_flag_bank_test;
    // ************************************************************
    // stimulus and observation signals
    // ************************************************************
    logic        mclk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [2:0]  addr_in = 3'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [15:0] rdata, rdata_red;
    logic [15:0] evt [5];
    logic [15:0] flags [5];
    logic [15:0] flags_red [5];
    logic [2:0]  prio, prio_red;
    logic        req, req_red;
    int          fails = 0;
    int          n_checks = 0;
    int          cycles = 0;
    // implemented bits per word, full and reduced members
    logic [15:0] mask_full [5] = '{ifp_pkg::MASK_FLAGS_1_FULL, ifp_pkg::MASK_FLAGS_2,
        ifp_pkg::MASK_FLAGS_3_FULL, ifp_pkg::MASK_FLAGS_4_FULL, ifp_pkg::MASK_FLAGS_5};
    logic [15:0] mask_red [5] = '{ifp_pkg::MASK_FLAGS_1_RED, ifp_pkg::MASK_FLAGS_2,
        ifp_pkg::MASK_FLAGS_3_RED, ifp_pkg::MASK_FLAGS_4_RED, ifp_pkg::MASK_FLAGS_5};

    // 25 MHz clock
    always #20 mclk_in = ~mclk_in;

    // ************************************************************
    // instances: full member, reduced member sharing all inputs
    // ************************************************************
    ifp_event_src u_src (.mclk_in(mclk_in), .evt1_out(evt[0]), .evt2_out(evt[1]),
        .evt3_out(evt[2]), .evt4_out(evt[3]), .evt5_out(evt[4]));
    ifp_flag_bank #(.FULL_MEMBER(1'b1)) u_dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata),
        .evt1_in(evt[0]), .evt2_in(evt[1]), .evt3_in(evt[2]), .evt4_in(evt[3]), .evt5_in(evt[4]),
        .flags1_out(flags[0]), .flags2_out(flags[1]), .flags3_out(flags[2]), .flags4_out(flags[3]),
        .flags5_out(flags[4]), .t3g_prio_out(prio), .t3g_req_out(req));
    ifp_flag_bank #(.FULL_MEMBER(1'b0)) u_dut_red (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_red),
        .evt1_in(evt[0]), .evt2_in(evt[1]), .evt3_in(evt[2]), .evt4_in(evt[3]), .evt5_in(evt[4]),
        .flags1_out(flags_red[0]), .flags2_out(flags_red[1]), .flags3_out(flags_red[2]),
        .flags4_out(flags_red[3]), .flags5_out(flags_red[4]), .t3g_prio_out(prio_red),
        .t3g_req_out(req_red));

    // ************************************************************
    // bus tasks and checks
    // ************************************************************
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr

    // read data is looked at only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [15:0] exp, input logic [15:0] exp_red);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        chk("rdata full", exp, rdata);
        chk("rdata reduced", exp_red, rdata_red);
    endtask : rd

    task automatic do_reset();
        @(posedge mclk_in);
        rstn_in <= 1'b0;
        repeat (16) @(posedge mclk_in);
        rstn_in <= 1'b1;
    endtask : do_reset

    // every index reads zero after reset except the priority default
    task automatic check_reset();
        for (int a = 0; a < 8; a++) begin
            rd(a[2:0], (a == 5) ? 16'h0040 : 16'h0000, (a == 5) ? 16'h0040 : 16'h0000);
        end
        chk("prio", 16'h0004, {13'h0, prio});
        chk("prio reduced", 16'h0004, {13'h0, prio_red});
    endtask : check_reset

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up

    // hang guard, far above the roughly 170 cycles the sequence needs
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            wrap_up();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        do_reset();
        check_reset();
        // software set and clear, then peripheral set, per word
        for (int w = 0; w < 5; w++) begin
            wr(w[2:0], 16'hFFFF);
            rd(w[2:0], mask_full[w], mask_red[w]);
            chk("flags out", mask_full[w], flags[w]);
            chk("flags out reduced", mask_red[w], flags_red[w]);
            wr(w[2:0], 16'h0000);
            rd(w[2:0], 16'h0000, 16'h0000);
            u_src.pulse(w[2:0], 16'hFFFF);
            rd(w[2:0], mask_full[w], mask_red[w]);
            wr(w[2:0], 16'h0000);
        end
        // event and clearing write land on the same edge
        fork
            wr(3'h0, 16'h0000);
            u_src.pulse(3'h0, 16'hFFFF);
        join
        rd(3'h0, mask_full[0], mask_red[0]);
        wr(3'h0, 16'h0000);
        // priority field holds only bits 6 to 4, unmapped indexes ignored
        wr(3'h5, 16'hFFFF);
        rd(3'h5, 16'h0070, 16'h0070);
        wr(3'h6, 16'hFFFF);
        wr(3'h7, 16'hFFFF);
        rd(3'h6, 16'h0000, 16'h0000);
        rd(3'h7, 16'h0000, 16'h0000);
        // timer3 gate request follows flag and priority
        u_src.pulse(3'h1, 16'h0020);
        repeat (2) @(posedge mclk_in);
        #1 chk("req prio 7", 16'h0001, {15'h0, req});
        chk("req prio 7 reduced", 16'h0001, {15'h0, req_red});
        wr(3'h5, 16'h0000);
        repeat (2) @(posedge mclk_in);
        #1 chk("req prio 0", 16'h0000, {15'h0, req});
        chk("req prio 0 reduced", 16'h0000, {15'h0, req_red});
        u_src.pulse(3'h1, 16'h0020);
        repeat (2) @(posedge mclk_in);
        #1 chk("req prio 0 again", 16'h0000, {15'h0, req});
        chk("req prio 0 again reduced", 16'h0000, {15'h0, req_red});
        wr(3'h5, 16'h0010);
        repeat (2) @(posedge mclk_in);
        #1 chk("req prio 1", 16'h0001, {15'h0, req});
        chk("req prio 1 reduced", 16'h0001, {15'h0, req_red});
        chk("prio 1", 16'h0001, {13'h0, prio});
        chk("prio 1 reduced", 16'h0001, {13'h0, prio_red});
        // second reset with flags set and priority changed
        u_src.pulse(3'h0, 16'hFFFF);
        do_reset();
        check_reset();
        wrap_up();
    end
endmodule : ifp_flag_bank_test
